// ### core/enhanced_capture_compare_pwm.sv
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - trigger mode match on timer a resets timer a to zero
// - trigger also starts a conversion when the converter is enabled
// - a timer write in the trigger cycle beats the reset
// - second unit trigger never sets the timer b overflow flag
// - mode zero turns everything off and resets the unit
// - capture on falling, rising, every 4th or 16th rising edge
// - toggle mode inverts the pin on every match
// - set mode starts low, clear mode starts high; both raise the flag
// - interrupt-only mode raises the flag, pin back to port
// - pwm codes set a/c and b/d polarity independently
// - non-pwm modes ignore output config; only output a used
// - single output: one pwm signal steered to the outputs enabled in steering control
// - forward: d modulated, a active, b and c inactive
// - half bridge: a and b complementary with dead band
// - reverse: b modulated, c active, a and d inactive
// - duty is 10 bits: low two from control, high eight from duty byte
// - trigger resets the selected timer and sets the match flag
// - capture/compare use a 16-bit timer, pwm the 8-bit period timer
// - pwm waits for next period start before producing output
// - clearing control releases all pins; unused pins stay free
// - dead band delays each active edge; too long keeps output off
// - direction change takes effect at the next pwm period
module enhanced_capture_compare_pwm #(
  parameter int ADDR_W = enhanced_unit_pkg::ADDR_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_b_count,
  input wire logic timer_a_write,
  input wire logic timer_b_write,
  input wire logic timer_b_overflow,
  input wire logic second_unit_trigger,
  input wire logic second_uses_timer_b,
  input wire logic adc_enabled,
  input wire logic [7:0] pwm_timer,
  input wire logic [1:0] pwm_phase,
  input wire logic pwm_period_start,
  input wire logic capture_in,
  output logic [3:0] pwm_out,
  output logic [3:0] pwm_oe,
  output logic timer_a_reset,
  output logic timer_b_reset,
  output logic adc_start
);
  // ************************************************
  // helpers
  // ************************************************
  function automatic logic reg_hit(input logic [4:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= enhanced_unit_pkg::OFS_CAPT);
  endfunction : reg_hit

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  enhanced_unit_pkg::state_t s_r;
  enhanced_unit_pkg::state_t s_nxt;

  function automatic logic [31:0] rd_word(input enhanced_unit_pkg::state_t s, input logic [4:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a == enhanced_unit_pkg::OFS_CTRL) begin
      r[7:0] = s.ctrl;
    end else if (a == enhanced_unit_pkg::OFS_DUTY) begin
      r[7:0] = s.duty_high_byte;
    end else if (a == enhanced_unit_pkg::OFS_CMP) begin
      r[15:0] = s.compare_value_pair;
    end else if (a == enhanced_unit_pkg::OFS_DBAND) begin
      r[6:0] = s.deadband_count;
    end else if (a == enhanced_unit_pkg::OFS_STEER) begin
      r[3:0] = s.steering_control;
    end else if (a == enhanced_unit_pkg::OFS_TSEL) begin
      r[0] = s.tsel;
    end else if (a == enhanced_unit_pkg::OFS_STAT) begin
      r[enhanced_unit_pkg::STAT_MATCH] = s.unit_match_flag;
      r[enhanced_unit_pkg::STAT_TBOVF] = s.timer_b_overflow_flag;
    end else if (a == enhanced_unit_pkg::OFS_CAPT) begin
      r[15:0] = s.capture_value;
    end
    rd_word = r;
  endfunction : rd_word

  // ************************************************
  // next state
  // ************************************************
  logic [3:0] mode;
  logic [15:0] tval;
  logic [31:0] wv;
  logic [9:0] cnt10;
  logic raw;
  logic mod_a;
  logic mod_b;
  logic [6:0] eff;
  logic [3:0] act;
  logic [3:0] steer_en;
  logic rise;
  logic fall;
  logic match_now;
  logic hit;
  logic grab;
  enhanced_unit_pkg::output_config_t oc;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ta_rst = 1'b0;
    s_nxt.tb_rst = 1'b0;
    s_nxt.adc_start = 1'b0;
    mode = s_r.ctrl.unit_mode_select;
    tval = s_r.tsel ? timer_b_count : timer_a_count;
    wv = merge(rd_word(s_r, s_r.aw_addr), s_r.wdata, s_r.wstrb);
    // bus write side
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.awready = 1'b0;
      s_nxt.aw_addr = s_axi_awaddr[4:0];
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.wready = 1'b0;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_hit(s_r.aw_addr) ? enhanced_unit_pkg::RESP_OKAY : enhanced_unit_pkg::RESP_SLVERR;
      if (s_r.aw_addr == enhanced_unit_pkg::OFS_CTRL) begin
        s_nxt.ctrl = wv[7:0];
        if (wv[3:0] == enhanced_unit_pkg::M_SET) begin
          s_nxt.pin = 1'b0;
        end else if (wv[3:0] == enhanced_unit_pkg::M_CLR) begin
          s_nxt.pin = 1'b1;
        end
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_DUTY) begin
        s_nxt.duty_high_byte = wv[7:0];
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_CMP) begin
        s_nxt.compare_value_pair = wv[15:0];
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_DBAND) begin
        s_nxt.deadband_count = wv[6:0];
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_STEER) begin
        s_nxt.steering_control = wv[3:0];
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_TSEL) begin
        s_nxt.tsel = wv[0];
      end else if (s_r.aw_addr == enhanced_unit_pkg::OFS_STAT && s_r.wstrb[0]) begin
        if (s_r.wdata[enhanced_unit_pkg::STAT_MATCH]) begin
          s_nxt.unit_match_flag = 1'b0;
        end
        if (s_r.wdata[enhanced_unit_pkg::STAT_TBOVF]) begin
          s_nxt.timer_b_overflow_flag = 1'b0;
        end
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
      s_nxt.awready = 1'b1;
      s_nxt.wready = 1'b1;
    end
    // bus read side
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word(s_r, s_axi_araddr[4:0]);
      s_nxt.rresp = reg_hit(s_axi_araddr[4:0]) ? enhanced_unit_pkg::RESP_OKAY : enhanced_unit_pkg::RESP_SLVERR;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    // overflow flag: only the timer's own overflow sets it
    if (timer_b_overflow) begin
      s_nxt.timer_b_overflow_flag = 1'b1;
    end
    // second unit trigger resets its timer, never sets the overflow flag
    if (second_unit_trigger) begin
      if (second_uses_timer_b) begin
        s_nxt.tb_rst = !timer_b_write;
      end else begin
        s_nxt.ta_rst = !timer_a_write;
      end
      s_nxt.adc_start = adc_enabled;
    end
    // ************************************************
    // capture and compare
    // ************************************************
    match_now = (tval == s_r.compare_value_pair);
    hit = match_now && !s_r.match_prev;
    s_nxt.match_prev = match_now;
    rise = capture_in && !s_r.cap_prev;
    fall = !capture_in && s_r.cap_prev;
    s_nxt.cap_prev = capture_in;
    grab = 1'b0;
    case (mode)
      enhanced_unit_pkg::M_TOGGLE: begin
        s_nxt.pin_en = 1'b1;
        if (hit) begin
          s_nxt.pin = ~s_r.pin;
        end
      end
      enhanced_unit_pkg::M_SET: begin
        s_nxt.pin_en = 1'b1;
        if (hit) begin
          s_nxt.pin = 1'b1;
          s_nxt.unit_match_flag = 1'b1;
        end
      end
      enhanced_unit_pkg::M_CLR: begin
        s_nxt.pin_en = 1'b1;
        if (hit) begin
          s_nxt.pin = 1'b0;
          s_nxt.unit_match_flag = 1'b1;
        end
      end
      enhanced_unit_pkg::M_SWINT: begin
        s_nxt.pin_en = 1'b0;
        if (hit) begin
          s_nxt.unit_match_flag = 1'b1;
        end
      end
      enhanced_unit_pkg::M_SPECIAL: begin
        s_nxt.pin_en = 1'b0;
        if (hit) begin
          s_nxt.unit_match_flag = 1'b1;
          if (s_r.tsel) begin
            s_nxt.tb_rst = !timer_b_write;
          end else begin
            s_nxt.ta_rst = !timer_a_write;
          end
          s_nxt.adc_start = adc_enabled;
        end
      end
      enhanced_unit_pkg::M_CAP_FALL: begin
        s_nxt.pin_en = 1'b0;
        grab = fall;
      end
      enhanced_unit_pkg::M_CAP_RISE: begin
        s_nxt.pin_en = 1'b0;
        grab = rise;
      end
      enhanced_unit_pkg::M_CAP_4, enhanced_unit_pkg::M_CAP_16: begin
        s_nxt.pin_en = 1'b0;
        if (rise) begin
          s_nxt.cap_cnt = s_r.cap_cnt + 4'h1;
          grab = (mode == enhanced_unit_pkg::M_CAP_4) ? (s_r.cap_cnt[1:0] == enhanced_unit_pkg::CNT4_LAST)
                                             : (s_r.cap_cnt == enhanced_unit_pkg::CNT16_LAST);
        end
      end
      default: begin
        s_nxt.pin_en = 1'b0;
        if (mode == enhanced_unit_pkg::M_OFF) begin
          s_nxt.pin = (s_nxt.ctrl.unit_mode_select == enhanced_unit_pkg::M_CLR);
          s_nxt.cap_cnt = 4'h0;
          s_nxt.pwm_run = 1'b0;
          s_nxt.db_cnt = 7'h00;
        end
      end
    endcase
    if (grab) begin
      s_nxt.capture_value = tval;
      s_nxt.unit_match_flag = 1'b1;
    end
    // ************************************************
    // pwm
    // ************************************************
    cnt10 = {pwm_timer, pwm_phase};
    raw = s_r.pwm_run && (cnt10 < s_r.duty_l);
    if (mode[3:2] != 2'h3) begin
      s_nxt.pwm_run = 1'b0;
    end else if (pwm_period_start) begin
      s_nxt.pwm_run = 1'b1;
      s_nxt.duty_l = {s_r.duty_high_byte, s_r.ctrl.duty_low_bits};
      s_nxt.dir_l = s_r.ctrl.output_config[1];
    end
    // dead band: count cycles since the raw signal last changed
    if (raw != s_r.raw_prev) begin
      eff = 7'h00;
    end else if (s_r.db_cnt != enhanced_unit_pkg::DB_MAX) begin
      eff = s_r.db_cnt + 7'h01;
    end else begin
      eff = s_r.db_cnt;
    end
    s_nxt.db_cnt = eff;
    s_nxt.raw_prev = raw;
    mod_a = raw && (eff >= s_r.deadband_count);
    mod_b = !raw && s_r.pwm_run && (eff >= s_r.deadband_count);
    if (s_r.ctrl.output_config[0]) begin
      oc = s_r.dir_l ? enhanced_unit_pkg::OC_REV : enhanced_unit_pkg::OC_FWD;
    end else begin
      oc = enhanced_unit_pkg::output_config_t'(s_r.ctrl.output_config);
    end
    steer_en = s_r.steering_control;
    case (oc)
      enhanced_unit_pkg::OC_SINGLE: begin
        act = {4{raw}};
        s_nxt.oe = steer_en;
      end
      enhanced_unit_pkg::OC_FWD: begin
        act = {raw, 1'b0, 1'b0, s_r.pwm_run};
        s_nxt.oe = 4'hF;
      end
      enhanced_unit_pkg::OC_HALF: begin
        act = {1'b0, 1'b0, mod_b, mod_a};
        s_nxt.oe = 4'h3;
      end
      default: begin
        act = {1'b0, s_r.pwm_run, raw, 1'b0};
        s_nxt.oe = 4'hF;
      end
    endcase
    if (mode[3:2] == 2'h3) begin
      s_nxt.out[0] = act[0] ^ mode[1];
      s_nxt.out[2] = act[2] ^ mode[1];
      s_nxt.out[1] = act[1] ^ mode[0];
      s_nxt.out[3] = act[3] ^ mode[0];
    end else begin
      s_nxt.out = {3'h0, s_r.pin};
      s_nxt.oe = {3'h0, s_r.pin_en && (mode != enhanced_unit_pkg::M_OFF)};
    end
  end

  // ************************************************
  // state register
  // ************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
      s_r.ctrl <= enhanced_unit_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign pwm_out = s_r.out;
  assign pwm_oe = s_r.oe;
  assign timer_a_reset = s_r.ta_rst;
  assign timer_b_reset = s_r.tb_rst;
  assign adc_start = s_r.adc_start;
endmodule : enhanced_capture_compare_pwm

// ### core/enhanced_unit_pkg.sv
package enhanced_unit_pkg;
  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_DUTY = 5'h04;
  localparam logic [4:0] OFS_CMP = 5'h08;
  localparam logic [4:0] OFS_DBAND = 5'h0C;
  localparam logic [4:0] OFS_STEER = 5'h10;
  localparam logic [4:0] OFS_TSEL = 5'h14;
  localparam logic [4:0] OFS_STAT = 5'h18;
  localparam logic [4:0] OFS_CAPT = 5'h1C;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STAT_MATCH = 0;
  localparam int STAT_TBOVF = 1;
  localparam logic [6:0] DB_MAX = 7'h7F;
  localparam logic [3:0] CNT16_LAST = 4'hF;
  localparam logic [1:0] CNT4_LAST = 2'h3;
  // ************************************************
  // mode codes
  // ************************************************
  localparam logic [3:0] M_OFF = 4'h0;
  localparam logic [3:0] M_TOGGLE = 4'h2;
  localparam logic [3:0] M_CAP_FALL = 4'h4;
  localparam logic [3:0] M_CAP_RISE = 4'h5;
  localparam logic [3:0] M_CAP_4 = 4'h6;
  localparam logic [3:0] M_CAP_16 = 4'h7;
  localparam logic [3:0] M_SET = 4'h8;
  localparam logic [3:0] M_CLR = 4'h9;
  localparam logic [3:0] M_SWINT = 4'hA;
  localparam logic [3:0] M_SPECIAL = 4'hB;
  typedef enum logic [1:0] {OC_SINGLE, OC_FWD, OC_HALF, OC_REV} output_config_t;
  // ************************************************
  // control register layout
  // ************************************************
  typedef struct packed {
    logic [1:0] output_config;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_select;
  } enhanced_unit_control_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_ok;
    logic w_ok;
    logic [4:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    enhanced_unit_control_t ctrl;
    logic [7:0] duty_high_byte;
    logic [15:0] compare_value_pair;
    logic [6:0] deadband_count;
    logic [3:0] steering_control;
    logic tsel;
    logic unit_match_flag;
    logic timer_b_overflow_flag;
    logic [15:0] capture_value;
    logic cap_prev;
    logic [3:0] cap_cnt;
    logic match_prev;
    logic pin;
    logic pin_en;
    logic pwm_run;
    logic [9:0] duty_l;
    logic dir_l;
    logic raw_prev;
    logic [6:0] db_cnt;
    logic [3:0] out;
    logic [3:0] oe;
    logic ta_rst;
    logic tb_rst;
    logic adc_start;
  } state_t;
endpackage : enhanced_unit_pkg

// ### testbench/enhanced_unit_drivers.sv
`timescale 1ns/1ps
// ****
// power switch drivers on the four pins
// ****
module enhanced_unit_drivers (
  input wire logic aclk,
  input wire logic [3:0] pwm_out,
  input wire logic [3:0] pwm_oe,
  output logic [3:0] sw_on
);
  // a released pin falls to its pull-down, so its switch stays off
  always_ff @(posedge aclk) begin
    sw_on <= pwm_out & pwm_oe;
  end
endmodule : enhanced_unit_drivers

// ### testbench/enhanced_unit_assertions.sv
`timescale 1ns/1ps
module enhanced_unit_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_a_write,
  input wire logic timer_b_write,
  input wire logic second_unit_trigger,
  input wire logic second_uses_timer_b,
  input wire logic adc_enabled,
  input wire logic [3:0] pwm_oe,
  input wire logic timer_a_reset,
  input wire logic timer_b_reset,
  input wire logic adc_start
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_TA_PULSE: assert property (timer_a_reset |=> !timer_a_reset)
    else $error("timer a reset too long");
  AST_TB_PULSE: assert property (timer_b_reset |=> !timer_b_reset)
    else $error("timer b reset too long");
  AST_ADC_GATE: assert property (adc_start |-> $past(adc_enabled) || $past(adc_enabled, 2))
    else $error("conversion start while converter off");
  AST_WRITE_WINS: assert property (timer_a_write |=> !timer_a_reset)
    else $error("reset beat a timer write");
  AST_WRITE_WINS_B: assert property (timer_b_write |=> !timer_b_reset)
    else $error("reset beat a timer b write");
  AST_SECOND_A: assert property (second_unit_trigger && !second_uses_timer_b && !timer_a_write |->
    ##[1:2] timer_a_reset)
    else $error("second trigger missed timer a");
  AST_SECOND_B: assert property (second_unit_trigger && second_uses_timer_b && !timer_b_write |->
    ##[1:2] timer_b_reset)
    else $error("second trigger missed timer b");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_RST_IDLE: assert property (disable iff (1'h0) !aresetn |=> pwm_oe == 4'h0 && !adc_start)
    else $error("unit not idle after reset");
  C_ADC: cover property (adc_start);
  C_TB: cover property (timer_b_reset);
  C_FULL: cover property (pwm_oe == 4'hF);
endmodule : enhanced_unit_assertions
bind enhanced_capture_compare_pwm enhanced_unit_assertions chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .timer_b_write,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_a_write,
  .second_unit_trigger, .second_uses_timer_b, .adc_enabled, .pwm_oe, .timer_a_reset, .timer_b_reset, .adc_start);

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  // ****
  // stimulus and observed signals
  // ****
  localparam logic [1:0] OK = enhanced_unit_pkg::RESP_OKAY;
  localparam logic [4:0] CT = enhanced_unit_pkg::OFS_CTRL;
  localparam logic [4:0] ST = enhanced_unit_pkg::OFS_STAT;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, wr_a = 1'h0, wr_b = 1'h0, ovf = 1'h0, trig2 = 1'h0, use_b = 1'h0, adc_en = 1'h0;
  logic cap = 1'h0, arm = 1'h0, sel = 1'h0, prun = 1'h0, pst = 1'h0, p0;
  logic [4:0] awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0, rd;
  logic [15:0] cnt_a = 16'h0, cnt_b = 16'h0, cmp = 16'h0, c;
  logic [9:0] pcnt = 10'h0, d;
  logic [3:0] m;
  logic [7:0] cc[4] = '{8'h48, 8'hC9, 8'h02, 8'h8A};
  int nn[4] = '{1, 1, 4, 16};
  int ha, hb, na, n, db, pc[4];
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'hB832;
  wire logic awready, wready, bvalid, arready, rvalid, ta_rst, tb_rst, adc_st;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [3:0] pout, poe, sw;
  always #5 aclk = ~aclk;
  // timers count the instruction clock, never an unsynchronised input
  always @(posedge aclk) begin
    cnt_a <= ta_rst ? 16'h0 : cnt_a + 16'h1;
    cnt_b <= tb_rst ? 16'h0 : cnt_b + 16'h1;
    wr_a <= arm && !sel && cnt_a == cmp - 16'h1;
    wr_b <= arm && sel && cnt_b == cmp - 16'h1;
    pst <= prun && pcnt == 10'h3F;
    if (prun) pcnt <= (pcnt == 10'h3F) ? 10'h0 : pcnt + 10'h1;
  end
  enhanced_capture_compare_pwm uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_a_count(cnt_a), .timer_b_count(cnt_b), .timer_a_write(wr_a), .timer_b_write(wr_b),
    .timer_b_overflow(ovf), .second_unit_trigger(trig2), .second_uses_timer_b(use_b), .adc_enabled(adc_en),
    .pwm_timer(pcnt[9:2]), .pwm_phase(pcnt[1:0]), .pwm_period_start(pst), .capture_in(cap),
    .pwm_out(pout), .pwm_oe(poe), .timer_a_reset(ta_rst), .timer_b_reset(tb_rst), .adc_start(adc_st));
  enhanced_unit_drivers drv (.aclk(aclk), .pwm_out(pout), .pwm_oe(poe), .sw_on(sw));
  // ****
  // helpers
  // ****
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int k);
    if (k > 80) begin
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      print_verdict();
    end
  endtask : tmo
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
    int k = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        chk(bresp, er);
        bready <= 1'h0;
      end
      tmo(++k);
    end while (awvalid || wvalid || bready);
  endtask : wr
  task automatic rdr(input logic [4:0] a, input logic [1:0] er);
    int k = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rd = rdata;
        chk(rresp, er);
        rready <= 1'h0;
      end
      tmo(++k);
    end while (arvalid || rready);
  endtask : rdr
  function automatic logic exp_pin(input logic [3:0] md, input logic pb, input logic hit);
    if (md == enhanced_unit_pkg::M_SET) return hit;
    if (md == enhanced_unit_pkg::M_CLR) return !hit;
    return hit ? !pb : pb;
  endfunction : exp_pin
  function automatic int exp_cnt(input logic [1:0] oc, input logic [3:0] md, input int j, input int dt,
                                 input int db);
    int act;
    logic inv;
    inv = j[0] ? md[0] : md[1];
    case (oc)
      2'h0: act = dt;
      2'h1: act = (j == 0) ? 64 : (j == 3) ? dt : 0;
      2'h2: act = (j == 0) ? ((dt > db) ? dt - db : 0) : (dt == 0) ? 64 : (64 - dt > db) ? 64 - dt - db : 0;
      default: act = (j == 2) ? 64 : (j == 1) ? dt : 0;
    endcase
    if (oc == 2'h2 && j > 1) return 0;
    return inv ? 64 - act : act;
  endfunction : exp_cnt
  // ****
  // scenarios
  // ****
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdr(CT, OK);
    chk(rd, 32'h0);
    wr(5'h1E, 32'hFF, enhanced_unit_pkg::RESP_SLVERR);
    rdr(5'h1E, enhanced_unit_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(CT, 32'hFF, OK);
    rdr(CT, OK);
    chk(rd, 32'hFF);
    chk(pout, 4'hF);
    wr(CT, 32'h0, OK);
    chk(poe, 4'h0);
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'h0, OK);
      wr(ST, 32'h3, OK);
      wr(enhanced_unit_pkg::OFS_TSEL, 32'(i[0]), OK);
      sel <= i[0];
      arm <= i[1];
      adc_en <= !i[0];
      c = (i[0] ? cnt_b : cnt_a) + 16'h20 + 16'($random(seed) & 7);
      cmp <= c;
      wr(enhanced_unit_pkg::OFS_CMP, 32'(c), OK);
      wr(CT, 32'h0B, OK);
      ha = 0;
      hb = 0;
      na = 0;
      repeat (60) begin
        @(posedge aclk);
        ha += ta_rst;
        hb += tb_rst;
        na += adc_st;
      end
      chk(i[0] ? hb : ha, 32'(!i[1]));
      chk(i[0] ? ha : hb, 0);
      rdr(ST, OK);
      chk(rd[1], 0);
      if (!i[1]) begin
        chk(na, 32'(!i[0]));
        chk(rd[0], 1);
      end
    end
    wr(CT, 32'h0, OK);
    arm <= 1'h0;
    for (int i = 0; i < 2; i++) begin
      use_b <= i[0];
      trig2 <= 1'h1;
      @(posedge aclk);
      trig2 <= 1'h0;
      hb = 0;
      repeat (4) begin
        @(posedge aclk);
        hb += i[0] ? tb_rst : ta_rst;
      end
      chk(hb, 1);
      rdr(ST, OK);
      chk(rd[1], 0);
    end
    ovf <= 1'h1;
    @(posedge aclk);
    ovf <= 1'h0;
    rdr(ST, OK);
    chk(rd[1], 1);
    for (int q = 0; q < 4; q++) begin
      wr(CT, 32'h0, OK);
      wr(ST, 32'h3, OK);
      wr(CT, 32'(4 + q), OK);
      for (int k = 1; k <= nn[q]; k++) begin
        cap <= 1'h1;
        repeat (2 + ($random(seed) & 3)) @(posedge aclk);
        if (k >= nn[q] - 1) begin
          rdr(ST, OK);
          chk(rd[0], 32'(k == nn[q] && q != 0));
        end
        cap <= 1'h0;
        repeat (2 + ($random(seed) & 3)) @(posedge aclk);
      end
      rdr(ST, OK);
      chk(rd[0], 1);
    end
    for (int i = 0; i < 4; i++) begin
      wr(CT, 32'h0, OK);
      wr(ST, 32'h3, OK);
      wr(enhanced_unit_pkg::OFS_TSEL, 32'h0, OK);
      c = cnt_a + 16'h20 + 16'($random(seed) & 7);
      wr(enhanced_unit_pkg::OFS_CMP, 32'(c), OK);
      wr(CT, 32'(cc[i]), OK);
      @(posedge aclk);
      p0 = pout[0];
      chk(poe, (i == 3) ? 4'h0 : 4'h1);
      if (i < 2) chk(p0, exp_pin(cc[i][3:0], 1'h0, 1'h0));
      repeat (50) @(posedge aclk);
      if (i < 3) chk(pout[0], exp_pin(cc[i][3:0], p0, 1'h1));
      rdr(ST, OK);
      if (i != 2) chk(rd[0], 1);
    end
    wr(enhanced_unit_pkg::OFS_DBAND, 32'h0, OK);
    wr(enhanced_unit_pkg::OFS_STEER, 32'hF, OK);
    for (int oc = 0; oc < 4; oc++) begin
      prun <= 1'h0;
      m = 4'hC + 4'($random(seed) & 3);
      d = 10'($random(seed) & 63);
      db = (oc == 2) ? ($random(seed) & 7) : 0;
      wr(enhanced_unit_pkg::OFS_DBAND, 32'(db), OK);
      wr(enhanced_unit_pkg::OFS_DUTY, 32'(d[9:2]), OK);
      wr(CT, {24'h0, oc[1:0], d[1:0], m}, OK);
      prun <= 1'h1;
      n = 0;
      while (!pst) begin
        @(posedge aclk);
        tmo(++n);
      end
      repeat (67) @(posedge aclk);
      pc = '{default: 0};
      repeat (64) begin
        @(posedge aclk);
        for (int j = 0; j < 4; j++) pc[j] += sw[j];
      end
      for (int j = 0; j < 4; j++) chk(pc[j], exp_cnt(oc[1:0], m, j, d, db));
    end
    prun <= 1'h0;
    wr(CT, {24'h0, 2'h1, d[1:0], m}, OK);
    @(posedge aclk);
    chk(pout[2], !m[1]);
    prun <= 1'h1;
    repeat (70) @(posedge aclk);
    chk(pout[2], m[1]);
    wr(CT, 32'h0, OK);
    chk(poe, 4'h0);
    print_verdict();
  end
endmodule : tb
